// File: pkg/dbt_pkg.sv
package dbt_pkg;

  // ==========================================================
  // Register map
  localparam logic [15:0] DBT_ADDR_CONTROL   = 16'hfe18;
  localparam logic [15:0] DBT_ADDR_PRESCALER = 16'hfe19;
  localparam logic [15:0] DBT_ADDR_LOW_CNT   = 16'hfe1a;
  localparam logic [15:0] DBT_ADDR_HIGH_CNT  = 16'hfe1b;
  localparam logic [15:0] DBT_ADDR_LOW_RLD   = 16'hfe1c;
  localparam logic [15:0] DBT_ADDR_HIGH_RLD  = 16'hfe1d;

  // ==========================================================
  // Reset values
  localparam logic [7:0] DBT_RST_CONTROL   = 8'h00;
  localparam logic [7:0] DBT_RST_PRESCALER = 8'h00;
  localparam logic [7:0] DBT_RST_COUNT     = 8'h00;
  localparam logic [7:0] DBT_RST_RELOAD    = 8'h00;
  localparam logic [7:0] DBT_RST_UNMAPPED  = 8'h00;
  localparam logic       DBT_RST_PIN       = 1'b1;
  localparam logic       DBT_RST_PHASE     = 1'b0;
  localparam logic [7:0] DBT_RELOAD_ONES   = 8'hff;
  localparam logic [7:0] DBT_COUNT_TOP     = 8'hff;

  // ==========================================================
  // Control register fields
  localparam int DBT_BIT_HIGH_RUN  = 7;
  localparam int DBT_BIT_LOW_RUN   = 6;
  localparam int DBT_BIT_LENGTH    = 5;
  localparam int DBT_BIT_OUT_MODE  = 4;
  localparam int DBT_BIT_HIGH_FLAG = 3;
  localparam int DBT_BIT_HIGH_IE   = 2;
  localparam int DBT_BIT_LOW_FLAG  = 1;
  localparam int DBT_BIT_LOW_IE    = 0;

  // ==========================================================
  // Prescaler control fields
  localparam int DBT_BIT_HIGH_PRE_EN = 7;
  localparam int DBT_POS_HIGH_CODE   = 4;
  localparam int DBT_BIT_LOW_PRE_EN  = 3;
  localparam int DBT_POS_LOW_CODE    = 0;
  localparam int DBT_CODE_W          = 3;

  // ==========================================================
  // Operating modes {bit length, output mode}
  typedef enum logic [1:0] {
    DBT_MODE_DUAL_TIMER  = 2'b00,
    DBT_MODE_DUAL_PWM    = 2'b01,
    DBT_MODE_CASCADE     = 2'b10,
    DBT_MODE_CASCADE_PWM = 2'b11
  } dbt_mode_t;

  // ==========================================================
  // Terminal count of a prescaler: 0 when off, 2^(code+1)-1 when on
  function automatic logic [7:0] dbt_prescale_limit(input logic en, input logic [2:0] code);
    logic [8:0] div;
    div = 9'h002 << code;
    dbt_prescale_limit = en ? 8'(div - 9'h001) : 8'h00;
  endfunction : dbt_prescale_limit

endpackage : dbt_pkg

// File: rtl/dbt_prescaler.sv
`timescale 1ns/1ps
module dbt_prescaler #(
  parameter int PRE_W = 8
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_clear,
  input  wire logic                         i_tick,
  input  wire logic                         i_enable,
  input  wire logic [dbt_pkg::DBT_CODE_W-1:0] i_code,
  output logic                              o_tick
);
  import dbt_pkg::*;

  initial begin
    if (PRE_W != 8) begin
      $error("dbt_prescaler supports PRE_W of 8 only");
    end
  end

  // ==========================================================
  // Divide counter
  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] cnt_d;
  logic [PRE_W-1:0] limit;

  always_comb begin
    limit  = dbt_prescale_limit(i_enable, i_code);
    o_tick = i_tick && (cnt_q == limit);
    cnt_d  = cnt_q;
    if (i_clear) begin
      cnt_d = '0;
    end else if (o_tick) begin
      cnt_d = '0;
    end else if (i_tick) begin
      cnt_d = PRE_W'(cnt_q + 1'b1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : dbt_prescaler

// File: rtl/dbt_timer.sv
// Notes on behaviour
// - Two control bits pick one of four modes: timers, PWMs, cascade, cascade with PWM.
// - Mode 0: two independent 8-bit timers counting half-rate cycle ticks.
// - Mode 0: low half may count external events; high half only half-rate ticks.
// - Mode 0: half period (reload+1)*prescale*2 cycles; output toggles each period.
// - Mode 1: two 8-bit PWMs, period 256*prescale, low time (reload+1)*prescale.
// - Mode 2: high half counts low-half periods, forming a 16-bit timer/counter.
// - Mode 2: low output toggles per low period, high output per full period.
// - Mode 3: low half is a PWM; high half counts its periods and toggles.
// - Each half's match (period end in timer modes, low-to-high point in PWM) raises its request when its enable bit is set.
// - Output high while its half stops; low while running with reload all ones.
// - Low prescaler runs only while the low run bit is set.
// - Low prescaler counts events or half-rate ticks in modes 0/2, cycles otherwise.
// - Prescaler divides by 1 when disabled, else by 2 up to 256.
// - Low prescaler clears whenever the timer stops.
// - High prescaler input: half-rate, cycle, low match, or low PWM period by mode.
// - Match buffer follows reload while stopped, reloads at zero count while running.
// - Low output toggles on match, or clears on overflow and sets on match.
// - Counters clear on match per mode; both clear and hold at zero when stopped.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module dbt_timer #(
  parameter int CNT_W = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic [15:0]       i_addr,
  input  wire logic [CNT_W-1:0]  i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [CNT_W-1:0]  o_rdata,
  input  wire logic              i_ext_count_select,
  input  wire logic              i_external_irq_four_input,
  output logic                   o_low_half_output,
  output logic                   o_high_half_output,
  output logic                   o_low_half_irq,
  output logic                   o_high_half_irq
);
  import dbt_pkg::*;

  initial begin
    if (CNT_W != 8) begin
      $error("dbt_timer supports CNT_W of 8 only");
    end
    if (DBT_POS_LOW_CODE + DBT_CODE_W > DBT_BIT_LOW_PRE_EN) begin
      $error("dbt_timer low code field overlaps its enable bit");
    end
    if (DBT_POS_HIGH_CODE + DBT_CODE_W > DBT_BIT_HIGH_PRE_EN) begin
      $error("dbt_timer high code field overlaps its enable bit");
    end
  end

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // Registers
  logic [CNT_W-1:0] timer_control_reg_q;
  logic [CNT_W-1:0] timer_control_reg_d;
  logic [CNT_W-1:0] prescaler_control_reg_q;
  logic [CNT_W-1:0] prescaler_control_reg_d;
  logic [CNT_W-1:0] low_half_reload_value_q;
  logic [CNT_W-1:0] low_half_reload_value_d;
  logic [CNT_W-1:0] high_half_reload_value_q;
  logic [CNT_W-1:0] high_half_reload_value_d;
  logic [CNT_W-1:0] low_half_counter_q;
  logic [CNT_W-1:0] low_half_counter_d;
  logic [CNT_W-1:0] high_half_counter_q;
  logic [CNT_W-1:0] high_half_counter_d;
  logic [CNT_W-1:0] low_buf_q;
  logic [CNT_W-1:0] low_buf_d;
  logic [CNT_W-1:0] high_buf_q;
  logic [CNT_W-1:0] high_buf_d;
  logic             low_out_q;
  logic             low_out_d;
  logic             high_out_q;
  logic             high_out_d;
  logic             half_rate_q;
  logic             half_rate_d;
  logic [CNT_W-1:0] rdata_q;
  logic [CNT_W-1:0] rdata_d;

  logic             low_half_run;
  logic             high_half_run;
  logic             output_mode_select;
  dbt_mode_t        mode;
  logic             low_src_tick;
  logic             high_src_tick;
  logic             low_pre_tick;
  logic             high_pre_tick;
  logic             low_match;
  logic             low_ovf;
  logic             high_match;
  logic             high_ovf;
  logic             high_pwm;
  logic             wr_ctrl;
  logic             sel_ctrl;
  logic             sel_pre;
  logic             sel_low_cnt;
  logic             sel_high_cnt;
  logic             sel_low_rld;
  logic             sel_high_rld;

  assign low_half_run       = timer_control_reg_q[DBT_BIT_LOW_RUN];
  assign high_half_run      = timer_control_reg_q[DBT_BIT_HIGH_RUN];
  assign output_mode_select = timer_control_reg_q[DBT_BIT_OUT_MODE];
  assign mode               = dbt_mode_t'({timer_control_reg_q[DBT_BIT_LENGTH], output_mode_select});
  assign high_pwm           = (mode == DBT_MODE_DUAL_PWM);

  // ==========================================================
  // Count sources
  always_comb begin
    half_rate_d = ~half_rate_q;
    if (output_mode_select) begin
      low_src_tick = low_half_run;
    end else if (i_ext_count_select) begin
      low_src_tick = low_half_run && i_external_irq_four_input;
    end else begin
      low_src_tick = low_half_run && half_rate_q;
    end
    case (mode)
      DBT_MODE_DUAL_TIMER:  high_src_tick = high_half_run && half_rate_q;
      DBT_MODE_DUAL_PWM:    high_src_tick = high_half_run;
      DBT_MODE_CASCADE:     high_src_tick = high_half_run && low_match;
      default:              high_src_tick = high_half_run && low_ovf;
    endcase
  end

  dbt_prescaler #(
    .PRE_W (CNT_W)
  ) u_low_pre (
    .i_clk    (i_clk),
    .i_rst_n  (rst_n),
    .i_clear  (!low_half_run),
    .i_tick   (low_src_tick),
    .i_enable (prescaler_control_reg_q[DBT_BIT_LOW_PRE_EN]),
    .i_code   (prescaler_control_reg_q[DBT_POS_LOW_CODE +: DBT_CODE_W]),
    .o_tick   (low_pre_tick)
  );

  dbt_prescaler #(
    .PRE_W (CNT_W)
  ) u_high_pre (
    .i_clk    (i_clk),
    .i_rst_n  (rst_n),
    .i_clear  (!high_half_run),
    .i_tick   (high_src_tick),
    .i_enable (prescaler_control_reg_q[DBT_BIT_HIGH_PRE_EN]),
    .i_code   (prescaler_control_reg_q[DBT_POS_HIGH_CODE +: DBT_CODE_W]),
    .o_tick   (high_pre_tick)
  );

  // ==========================================================
  // Counters, match buffers and outputs
  always_comb begin
    low_match  = low_pre_tick && (low_half_counter_q == low_buf_q);
    low_ovf    = low_pre_tick && (low_half_counter_q == DBT_COUNT_TOP);
    high_match = high_pre_tick && (high_half_counter_q == high_buf_q);
    high_ovf   = high_pre_tick && (high_half_counter_q == DBT_COUNT_TOP);

    low_half_counter_d = low_half_counter_q;
    if (!low_half_run) begin
      low_half_counter_d = DBT_RST_COUNT;
    end else if (low_match && !output_mode_select) begin
      low_half_counter_d = DBT_RST_COUNT;
    end else if (low_pre_tick) begin
      low_half_counter_d = CNT_W'(low_half_counter_q + 1'b1);
    end

    high_half_counter_d = high_half_counter_q;
    if (!high_half_run) begin
      high_half_counter_d = DBT_RST_COUNT;
    end else if (high_match && !high_pwm) begin
      high_half_counter_d = DBT_RST_COUNT;
    end else if (high_pre_tick) begin
      high_half_counter_d = CNT_W'(high_half_counter_q + 1'b1);
    end

    low_buf_d = low_buf_q;
    if (!low_half_run || (low_pre_tick && low_half_counter_d == DBT_RST_COUNT)) begin
      low_buf_d = low_half_reload_value_q;
    end
    high_buf_d = high_buf_q;
    if (!high_half_run || (high_pre_tick && high_half_counter_d == DBT_RST_COUNT)) begin
      high_buf_d = high_half_reload_value_q;
    end

    low_out_d = low_out_q;
    if (!low_half_run) begin
      low_out_d = 1'b1;
    end else if (low_half_reload_value_q == DBT_RELOAD_ONES) begin
      low_out_d = 1'b0;
    end else if (output_mode_select) begin
      if (low_ovf) begin
        low_out_d = 1'b0;
      end else if (low_match) begin
        low_out_d = 1'b1;
      end
    end else if (low_match) begin
      low_out_d = ~low_out_q;
    end

    high_out_d = high_out_q;
    if (!high_half_run) begin
      high_out_d = 1'b1;
    end else if (high_half_reload_value_q == DBT_RELOAD_ONES) begin
      high_out_d = 1'b0;
    end else if (high_pwm) begin
      if (high_ovf) begin
        high_out_d = 1'b0;
      end else if (high_match) begin
        high_out_d = 1'b1;
      end
    end else if (high_match) begin
      high_out_d = ~high_out_q;
    end
  end

  // ==========================================================
  // Address decode
  always_comb begin
    sel_ctrl     = 1'b0;
    sel_pre      = 1'b0;
    sel_low_cnt  = 1'b0;
    sel_high_cnt = 1'b0;
    sel_low_rld  = 1'b0;
    sel_high_rld = 1'b0;
    if (i_addr == DBT_ADDR_CONTROL) begin
      sel_ctrl = 1'b1;
    end else if (i_addr == DBT_ADDR_PRESCALER) begin
      sel_pre = 1'b1;
    end else if (i_addr == DBT_ADDR_LOW_CNT) begin
      sel_low_cnt = 1'b1;
    end else if (i_addr == DBT_ADDR_HIGH_CNT) begin
      sel_high_cnt = 1'b1;
    end else if (i_addr == DBT_ADDR_LOW_RLD) begin
      sel_low_rld = 1'b1;
    end else if (i_addr == DBT_ADDR_HIGH_RLD) begin
      sel_high_rld = 1'b1;
    end
  end

  // ==========================================================
  // Register bus
  always_comb begin
    wr_ctrl                  = i_wr && sel_ctrl;
    timer_control_reg_d      = timer_control_reg_q;
    prescaler_control_reg_d  = prescaler_control_reg_q;
    low_half_reload_value_d  = low_half_reload_value_q;
    high_half_reload_value_d = high_half_reload_value_q;
    if (wr_ctrl) begin
      timer_control_reg_d = i_wdata;
    end
    if (i_wr && sel_pre) begin
      prescaler_control_reg_d = i_wdata;
    end else if (i_wr && sel_low_rld) begin
      low_half_reload_value_d = i_wdata;
    end else if (i_wr && sel_high_rld) begin
      high_half_reload_value_d = i_wdata;
    end
    if (low_match) begin
      timer_control_reg_d[DBT_BIT_LOW_FLAG] = 1'b1;
    end
    if (high_match) begin
      timer_control_reg_d[DBT_BIT_HIGH_FLAG] = 1'b1;
    end

    rdata_d = DBT_RST_UNMAPPED;
    if (!i_rd) begin
      rdata_d = DBT_RST_UNMAPPED;
    end else if (sel_ctrl) begin
      rdata_d = timer_control_reg_q;
    end else if (sel_pre) begin
      rdata_d = prescaler_control_reg_q;
    end else if (sel_low_cnt) begin
      rdata_d = low_half_counter_q;
    end else if (sel_high_cnt) begin
      rdata_d = high_half_counter_q;
    end else if (sel_low_rld) begin
      rdata_d = low_half_reload_value_q;
    end else if (sel_high_rld) begin
      rdata_d = high_half_reload_value_q;
    end
  end

  // ==========================================================
  // State registers
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_reg_q      <= DBT_RST_CONTROL;
      prescaler_control_reg_q  <= DBT_RST_PRESCALER;
      low_half_reload_value_q  <= DBT_RST_RELOAD;
      high_half_reload_value_q <= DBT_RST_RELOAD;
      rdata_q                  <= DBT_RST_UNMAPPED;
    end else begin
      timer_control_reg_q      <= timer_control_reg_d;
      prescaler_control_reg_q  <= prescaler_control_reg_d;
      low_half_reload_value_q  <= low_half_reload_value_d;
      high_half_reload_value_q <= high_half_reload_value_d;
      rdata_q                  <= rdata_d;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_half_counter_q  <= DBT_RST_COUNT;
      high_half_counter_q <= DBT_RST_COUNT;
      low_buf_q           <= DBT_RST_RELOAD;
      high_buf_q          <= DBT_RST_RELOAD;
    end else begin
      low_half_counter_q  <= low_half_counter_d;
      high_half_counter_q <= high_half_counter_d;
      low_buf_q           <= low_buf_d;
      high_buf_q          <= high_buf_d;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_out_q   <= DBT_RST_PIN;
      high_out_q  <= DBT_RST_PIN;
      half_rate_q <= DBT_RST_PHASE;
    end else begin
      low_out_q   <= low_out_d;
      high_out_q  <= high_out_d;
      half_rate_q <= half_rate_d;
    end
  end

  // ==========================================================
  // Outputs
  assign o_rdata            = rdata_q;
  assign o_low_half_output  = low_out_q;
  assign o_high_half_output = high_out_q;
  assign o_low_half_irq     = timer_control_reg_q[DBT_BIT_LOW_FLAG] && timer_control_reg_q[DBT_BIT_LOW_IE];
  assign o_high_half_irq    = timer_control_reg_q[DBT_BIT_HIGH_FLAG] && timer_control_reg_q[DBT_BIT_HIGH_IE];

endmodule : dbt_timer

// File: sim/dbt_timer_assertions.sv
`timescale 1ns/1ps
module dbt_timer_assertions #(
  parameter int CNT_W = 8
) (
  input wire logic             i_clk,
  input wire logic             i_resetn,
  input wire logic [15:0]      i_addr,
  input wire logic [CNT_W-1:0] i_wdata,
  input wire logic             i_wr,
  input wire logic             i_rd,
  input wire logic [CNT_W-1:0] o_rdata,
  input wire logic             i_ext_count_select,
  input wire logic             i_external_irq_four_input,
  input wire logic             o_low_half_output,
  input wire logic             o_high_half_output,
  input wire logic             o_low_half_irq,
  input wire logic             o_high_half_irq
);
  import dbt_pkg::*;
  logic [CNT_W-1:0] ctl_q;
  logic [CNT_W-1:0] rld_q;
  // ==========================================================
  // Shadow of software writes
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_q <= '0;
      rld_q <= '0;
    end else if (i_wr) begin
      if (i_addr == DBT_ADDR_CONTROL) ctl_q <= i_wdata;
      if (i_addr == DBT_ADDR_LOW_RLD) rld_q <= i_wdata;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ==========================================================
  // Properties
  property p_low_stop;   (!ctl_q[6]) [*3] |-> o_low_half_output; endproperty
  property p_high_stop;  (!ctl_q[7]) [*3] |-> o_high_half_output; endproperty
  property p_low_ones;   (ctl_q[6] && rld_q == 8'hff) [*3] |-> !o_low_half_output; endproperty
  property p_low_mask;   (!ctl_q[0]) [*2] |-> !o_low_half_irq; endproperty
  property p_high_mask;  (!ctl_q[2]) [*2] |-> !o_high_half_irq; endproperty
  property p_cnt_stop;
    i_rd && i_addr == DBT_ADDR_LOW_CNT && !ctl_q[6] && !$past(ctl_q[6]) |=> o_rdata == 8'h00;
  endproperty
  property p_rld_read;   i_rd && i_addr == DBT_ADDR_LOW_RLD |=> o_rdata == $past(rld_q); endproperty
  property p_ctl_read;
    i_rd && i_addr == DBT_ADDR_CONTROL |=> (o_rdata & 8'hf5) == ($past(ctl_q) & 8'hf5);
  endproperty
  property p_idle_read;  !i_rd |=> o_rdata == 8'h00; endproperty
  a_low_stop:  assert property (p_low_stop) else $error("low pin not high while stopped");
  a_high_stop: assert property (p_high_stop) else $error("high pin not high while stopped");
  a_low_ones:  assert property (p_low_ones) else $error("low pin not low with reload ones");
  a_low_mask:  assert property (p_low_mask) else $error("low irq while disabled");
  a_high_mask: assert property (p_high_mask) else $error("high irq while disabled");
  a_cnt_stop:  assert property (p_cnt_stop) else $error("stopped counter not zero");
  a_rld_read:  assert property (p_rld_read) else $error("reload readback wrong");
  a_ctl_read:  assert property (p_ctl_read) else $error("control readback wrong");
  a_idle_read: assert property (p_idle_read) else $error("read data not zero when idle");
  c_irq:   cover property (o_low_half_irq && o_high_half_irq);
  c_pwm:   cover property (ctl_q[6] && ctl_q[4] && !o_low_half_output);
  c_chain: cover property (ctl_q[5] && !o_high_half_output);
endmodule : dbt_timer_assertions

// File: sim/test_dbt_timer.sv
`timescale 1ns/1ps
module test_dbt_timer;
  import dbt_pkg::*;
  logic        i_clk, i_resetn, i_wr, i_rd, i_ext_count_select, i_external_irq_four_input;
  logic [15:0] i_addr, n;
  logic [7:0]  i_wdata, o_rdata, d, pr;
  logic        o_low_half_output, o_high_half_output, o_low_half_irq, o_high_half_irq;
  int          err_total, tests_run, k;
  dbt_timer #(.CNT_W(8)) i_dbt_timer (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_ext_count_select(i_ext_count_select), .i_external_irq_four_input(i_external_irq_four_input),
    .o_low_half_output(o_low_half_output), .o_high_half_output(o_high_half_output),
    .o_low_half_irq(o_low_half_irq), .o_high_half_irq(o_high_half_irq));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ==========================================================
  // Bus and check tasks
  task automatic tick(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask : rd
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  function automatic logic pin(input bit hi);
    return hi ? o_high_half_output : o_low_half_output;
  endfunction : pin
  function automatic int dv(input logic en, input logic [2:0] code);
    return en ? (2 << code) : 1;
  endfunction : dv
  // Length of the next full stretch of a pin at one level
  task automatic span(input bit hi, input logic lvl, output logic [15:0] c);
    int j;
    c = 0;
    for (j = 0; j < 4000 && pin(hi) === lvl; j++) tick(1);
    for (j = 0; j < 4000 && pin(hi) !== lvl; j++) tick(1);
    for (j = 0; j < 4000 && pin(hi) === lvl; j++) begin
      tick(1);
      c++;
    end
  endtask : span
  task automatic cfg(input logic [7:0] lr, input logic [7:0] hr, input logic [7:0] p, input logic [7:0] ctl);
    wr(DBT_ADDR_CONTROL, 8'h00);
    wr(DBT_ADDR_LOW_RLD, lr);
    wr(DBT_ADDR_HIGH_RLD, hr);
    wr(DBT_ADDR_PRESCALER, p);
    wr(DBT_ADDR_CONTROL, ctl);
  endtask : cfg
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (90000) @(posedge i_clk);
    err_total++;
    give_verdict();
  end
  // ==========================================================
  // Tests
  initial begin
    err_total = 0;
    tests_run = 0;
    i_resetn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    i_ext_count_select = 1'b0;
    i_external_irq_four_input = 1'b0;
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    tick(3);
    for (k = 0; k < 6; k++) begin
      rd(DBT_ADDR_CONTROL + 16'(k), d);
      chk("reset value", d, 8'h00);
    end
    rd(16'hfe1e, d);
    chk("unmapped read", d, 8'h00);
    wr(DBT_ADDR_LOW_CNT, 8'h55);
    rd(DBT_ADDR_LOW_CNT, d);
    chk("read-only count", d, 8'h00);
    $display("test reset done");
    for (k = 0; k < 9; k++) begin
      pr = (k == 8) ? 8'h00 : (8'h08 | 8'(k));
      cfg(8'h02, 8'h00, pr, 8'h40);
      span(1'b0, 1'b0, n);
      chk("low half period", n, 16'(3 * dv(pr[3], pr[2:0]) * 2));
    end
    cfg(8'h00, 8'h02, 8'h90, 8'h80);
    span(1'b1, 1'b0, n);
    chk("high half period", n, 16'd24);
    $display("test mode0 done");
    @(posedge i_clk);
    i_ext_count_select <= 1'b1;
    cfg(8'h09, 8'h00, 8'h00, 8'h40);
    repeat (5) begin
      @(posedge i_clk);
      i_external_irq_four_input <= 1'b1;
      @(posedge i_clk);
      i_external_irq_four_input <= 1'b0;
      @(posedge i_clk);
    end
    rd(DBT_ADDR_LOW_CNT, d);
    chk("event count", d, 8'h05);
    tick(20);
    rd(DBT_ADDR_LOW_CNT, d);
    chk("event count idle", d, 8'h05);
    @(posedge i_clk);
    i_ext_count_select <= 1'b0;
    $display("test events done");
    cfg(8'h3f, 8'h7f, 8'h00, 8'hd0);
    span(1'b0, 1'b0, n);
    chk("pwm low time", n, 16'd64);
    span(1'b0, 1'b1, n);
    chk("pwm high time", n, 16'd192);
    span(1'b1, 1'b0, n);
    chk("pwm high ch low time", n, 16'd128);
    $display("test mode1 done");
    cfg(8'h01, 8'h02, 8'h00, 8'he0);
    span(1'b0, 1'b0, n);
    chk("cascade low toggle", n, 16'd4);
    span(1'b1, 1'b0, n);
    chk("cascade high toggle", n, 16'd12);
    cfg(8'h07, 8'h00, 8'h00, 8'hf0);
    span(1'b0, 1'b0, n);
    chk("mode3 pwm low time", n, 16'd8);
    span(1'b1, 1'b0, n);
    chk("mode3 high toggle", n, 16'd256);
    $display("test cascade done");
    cfg(8'h03, 8'h03, 8'h00, 8'hc5);
    for (k = 0; k < 200 && !(o_low_half_irq === 1'b1 && o_high_half_irq === 1'b1); k++) tick(1);
    chk("low irq", o_low_half_irq, 1'b1);
    chk("high irq", o_high_half_irq, 1'b1);
    rd(DBT_ADDR_CONTROL, d);
    chk("match flags", d & 8'h0a, 8'h0a);
    wr(DBT_ADDR_CONTROL, 8'hc0);
    tick(2);
    chk("low irq masked", o_low_half_irq, 1'b0);
    $display("test irq done");
    cfg(8'hff, 8'hff, 8'h00, 8'hc0);
    tick(6);
    chk("low pin ones", o_low_half_output, 1'b0);
    chk("high pin ones", o_high_half_output, 1'b0);
    wr(DBT_ADDR_CONTROL, 8'h00);
    tick(3);
    chk("low pin stopped", o_low_half_output, 1'b1);
    chk("high pin stopped", o_high_half_output, 1'b1);
    rd(DBT_ADDR_LOW_CNT, d);
    chk("stopped count", d, 8'h00);
    $display("test stop done");
    cfg(8'h05, 8'h01, 8'h88, 8'hc5);
    tick(40);
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    tick(3);
    for (k = 0; k < 6; k++) begin
      rd(DBT_ADDR_CONTROL + 16'(k), d);
      chk("register after reset", d, 8'h00);
    end
    chk("low pin after reset", o_low_half_output, 1'b1);
    chk("high pin after reset", o_high_half_output, 1'b1);
    chk("low irq after reset", o_low_half_irq, 1'b0);
    $display("test midrun reset done");
    give_verdict();
  end
endmodule : test_dbt_timer
bind dbt_timer dbt_timer_assertions #(.CNT_W(CNT_W)) i_dbt_timer_assertions (.i_clk(i_clk),
  .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_ext_count_select(i_ext_count_select), .i_external_irq_four_input(i_external_irq_four_input),
  .o_low_half_output(o_low_half_output), .o_high_half_output(o_high_half_output),
  .o_low_half_irq(o_low_half_irq), .o_high_half_irq(o_high_half_irq));
